/* File: inc/octal_store_pkg.sv */
package octal_store_pkg;

   // number of storage bits in the register
   localparam int unsigned STORE_WIDTH = 8;

   // system clock rate
   localparam int unsigned REF_CLK_MHZ = 100;
   localparam int unsigned REF_CLK_PERIOD_NS = 10;

   // phase of the sampled data clock pin, gray along the low-high path
   typedef enum logic [0:0]
   {
      PH_LOW = 1'b0,
      PH_HIGH = 1'b1
   } clk_phase_e;

   // reset values of the control state
   localparam clk_phase_e PHASE_RST = PH_HIGH;
   localparam logic CE_LAT_RST = 1'b1;
   localparam logic LOADED_RST = 1'b0;

   // enable level that allows a capture (active low)
   localparam logic CE_ACTIVE = 1'b0;

endpackage

/* File: hw/bit_store_cell.sv */
`timescale 1ns/10ps

module bit_store_cell
(
   input wire logic ref_clk,
   input wire logic cap_en,
   input wire logic d,
   output logic q
);

   // no reset: the stored bit stays unknown until the first capture
   always_ff @(posedge ref_clk)
   begin
      if (cap_en)
      begin
         q <= d; // see RULE_03
      end
   end

endmodule

/* File: hw/octal_store_reg.sv */
// Functional notes
// RULE_01: eight bit cells, shared clock and enable
// RULE_02: cells update only on a rising clock
// RULE_03: enable low captures data, high holds
// RULE_04: steady clock level ignores data changes
// RULE_05: one latched enable gates all bits
// RULE_06: enable changes never cause a capture
// RULE_07: no data reset, unknown until first capture
`timescale 1ns/10ps

module octal_store_reg
   import octal_store_pkg::*;
#(
   parameter int unsigned WIDTH = octal_store_pkg::STORE_WIDTH
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] data_in,
   input wire logic ce_n,
   input wire logic data_clk,
   output logic [WIDTH-1:0] data_out,
   output logic loaded
);

   import octal_store_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   clk_phase_e phase_q;
   clk_phase_e phase_d;
   logic ce_lat_q;
   logic ce_lat_d;
   logic loaded_q;
   logic loaded_d;

   wire logic clk_rise;
   wire logic clk_fall;
   wire logic clk_low_now;
   wire logic cap_en;

   ////////////////////////////////////////////////////////////////////////////
   // data clock edge detection
   // the pin is sampled on ref_clk; the phase resets to high so that a pin
   // already high at reset release is not mistaken for a rising edge

   assign phase_d = data_clk ? PH_HIGH : PH_LOW;
   assign clk_rise = (phase_q == PH_LOW) && data_clk; // see RULE_02
   assign clk_fall = (phase_q == PH_HIGH) && !data_clk;
   assign clk_low_now = !data_clk;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= PHASE_RST;
      end
      else
      begin
         phase_q <= phase_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable latch
   // transparent while the data clock is low, frozen while it is high;
   // the enable must therefore be set up one ref_clk cycle before the rise,
   // which trades one cycle of setup for immunity to enable glitches

   assign ce_lat_d = clk_low_now ? ce_n : ce_lat_q; // see RULE_05

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ce_lat_q <= CE_LAT_RST;
      end
      else
      begin
         ce_lat_q <= ce_lat_d;
      end
   end

   // only a qualified rising edge captures; the raw pin plays no part
   // data plays no part in the strobe, so a steady level never captures
   assign cap_en = clk_rise && (ce_lat_q == CE_ACTIVE); // see RULE_04 RULE_06

   ////////////////////////////////////////////////////////////////////////////
   // storage cells, one per bit, all on the same capture strobe

   generate
      for (genvar i = 0; i < WIDTH; i++)
      begin : g_cell
         bit_store_cell u_cell
         (
            .ref_clk(ref_clk),
            .cap_en(cap_en),
            .d(data_in[i]),
            .q(data_out[i])
         ); // see RULE_01
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // loaded flag
   // the data cells carry no reset; this flag tells the user when
   // data_out first holds a defined value

   assign loaded_d = loaded_q || cap_en; // see RULE_07

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         loaded_q <= LOADED_RST;
      end
      else
      begin
         loaded_q <= loaded_d;
      end
   end

   assign loaded = loaded_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_rise;
      (phase_q == PH_LOW) && data_clk;
   endsequence

   sequence s_enabled_rise;
      s_rise ##0 (ce_lat_q == CE_ACTIVE);
   endsequence

   sequence s_disabled_rise;
      s_rise ##0 (ce_lat_q != CE_ACTIVE);
   endsequence

   sequence s_steady_clk;
      ((phase_q == PH_HIGH) && data_clk) ||
         ((phase_q == PH_LOW) && !data_clk);
   endsequence

   // all bits take the inputs one cycle after an enabled rise
   property p_capture_all;
      @(posedge ref_clk) disable iff (!rst_n)
      s_enabled_rise |=> (data_out == $past(data_in));
   endproperty
   a_capture_all: assert property (p_capture_all) // see RULE_01
      else $error("data_out did not take data_in on an enabled rise");

   // a rise with the enable high holds every bit
   property p_hold_disabled;
      @(posedge ref_clk) disable iff (!rst_n)
      loaded_q ##0 s_disabled_rise |=> $stable(data_out);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled) // see RULE_03
      else $error("data_out changed on a rise with the enable high");

   // a falling edge never updates the outputs
   property p_no_fall_update;
      @(posedge ref_clk) disable iff (!rst_n)
      (loaded_q && clk_fall) |=> $stable(data_out);
   endproperty
   a_no_fall_update: assert property (p_no_fall_update) // see RULE_02
      else $error("data_out changed on a falling data clock");

   // a steady clock level ignores data changes over two cycles
   property p_steady_level;
      @(posedge ref_clk) disable iff (!rst_n)
      (loaded_q ##0 s_steady_clk ##0 $changed(data_in)) |=>
         $stable(data_out);
   endproperty
   a_steady_level: assert property (p_steady_level) // see RULE_04
      else $error("data_out followed data_in at a steady clock level");

   // the latched enable is frozen while the data clock is high
   property p_ce_frozen;
      @(posedge ref_clk) disable iff (!rst_n)
      data_clk |=> (ce_lat_q == $past(ce_lat_q));
   endproperty
   a_ce_frozen: assert property (p_ce_frozen) // see RULE_05
      else $error("latched enable moved while the data clock was high");

   // the latched enable follows the pin one cycle later while clock is low
   property p_ce_follow;
      @(posedge ref_clk) disable iff (!rst_n)
      !data_clk |=> (ce_lat_q == $past(ce_n));
   endproperty
   a_ce_follow: assert property (p_ce_follow) // see RULE_05
      else $error("latched enable did not follow the pin at clock low");

   // an enable transition without a rise leaves the outputs alone
   property p_ce_no_false_clock;
      @(posedge ref_clk) disable iff (!rst_n)
      (loaded_q && $changed(ce_n) && !clk_rise) |=> $stable(data_out);
   endproperty
   a_ce_no_false_clock: assert property (p_ce_no_false_clock) // see RULE_06
      else $error("an enable transition changed data_out");

   // an enable pulse confined to the clock-high phase causes no capture
   property p_ce_pulse_high;
      @(posedge ref_clk) disable iff (!rst_n)
      (loaded_q && data_clk && (phase_q == PH_HIGH) && ce_lat_q) ##1
         (data_clk && !ce_n) [*2] |=> $stable(data_out);
   endproperty
   a_ce_pulse_high: assert property (p_ce_pulse_high) // see RULE_06
      else $error("enable low during clock high caused a capture");

   // loaded is set one cycle after every capture and stays set for three cycles
   property p_loaded_set;
      @(posedge ref_clk) disable iff (!rst_n)
      s_enabled_rise |=> loaded_q [*3];
   endproperty
   a_loaded_set: assert property (p_loaded_set) // see RULE_07
      else $error("loaded did not set and stay after a capture");

   property p_loaded_cause;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(loaded_q) |-> $past(cap_en);
   endproperty
   a_loaded_cause: assert property (p_loaded_cause) // see RULE_07
      else $error("loaded rose without a capture");

endmodule

/* File: testbench/strobe_source.sv */
`timescale 1ns/10ps

module strobe_source
(
   input wire logic ref_clk,
   output logic [7:0] data_in,
   output logic ce_n,
   output logic data_clk
);
   initial
   begin
      // pin high at time zero, so reset release must not see a rise
      data_clk = 1'b1;
      ce_n = 1'b1;
      data_in = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // one full clock pulse; enable and data are disturbed at the high level, data again at the low
   // so that any stray capture shows up in data_out afterwards; the high
   // level lasts four samples so an enable pulse fits wholly inside it
   task automatic strobe(input logic [7:0] d, input logic en_n);
      @(posedge ref_clk);
      #1;
      data_clk = 1'b0;
      ce_n = en_n;
      data_in = d;
      @(posedge ref_clk);
      #1;
      data_clk = 1'b1;
      @(posedge ref_clk);
      #1;
      ce_n = ~en_n;
      data_in = ~d;
      repeat (3) @(posedge ref_clk);
      #1;
      data_clk = 1'b0;
      data_in = d ^ 8'h3C;
      @(posedge ref_clk);
      #1;
   endtask
endmodule

/* File: testbench/octal_store_reg_tb.sv */
`timescale 1ns/10ps

module octal_store_reg_tb;
   import octal_store_pkg::*;

   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] data_in;
   logic ce_n;
   logic data_clk;
   logic [7:0] data_out;
   logic loaded;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;

   always #5 ref_clk = ~ref_clk;

   octal_store_reg uut
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .data_in(data_in),
      .ce_n(ce_n),
      .data_clk(data_clk),
      .data_out(data_out),
      .loaded(loaded)
   );

   strobe_source src
   (
      .ref_clk(ref_clk),
      .data_in(data_in),
      .ce_n(ce_n),
      .data_clk(data_clk)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // the whole run needs well under a hundred cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_errors++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic t_start;
      repeat (2) @(posedge ref_clk);
      #1;
      check({7'h00, loaded}, 8'h00);
      src.strobe(8'h96, 1'b1);
      check({7'h00, loaded}, 8'h00);
   endtask

   task automatic t_load;
      logic [7:0] pats [4];
      pats = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
      foreach (pats[i])
      begin
         src.strobe(pats[i], 1'b0);
         check(data_out, pats[i]);
         check({7'h00, loaded}, 8'h01);
      end
   endtask

   task automatic t_hold;
      src.strobe(8'h3C, 1'b1);
      check(data_out, 8'h5A);
   endtask

   task automatic t_reset;
      @(posedge ref_clk);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check({7'h00, loaded}, 8'h00);
      check(data_out, 8'h5A);
      rst_n = 1'b1;
      src.strobe(8'hC3, 1'b0);
      check(data_out, 8'hC3);
      check({7'h00, loaded}, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      t_start();
      t_load();
      t_hold();
      t_reset();
      results();
   end
endmodule
